// file: rtl/channel_range_map.sv
// Per-channel range decoder: range code and extension bit to full scale.
`timescale 1ns/100ps
`default_nettype none
module channel_range_map
  import overrange_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] rangeCode,
  input wire logic extend,
  output logic [13:0] fullScaleMv_q
);

  // Next full-scale value in millivolts.
  logic [13:0] fullScaleMv_d;

  // Decode the code into a magnitude, widened by the extension bit.
  always_comb
  begin
    unique case (rangeCode)
      // Both codes 00 and 11 select the ten volt range.
      CODE_10V_A, CODE_10V_B:
      begin
        fullScaleMv_d = extend ? FS_12V_MV : FS_10V_MV; // R10 R4
      end
      // Code 01 selects the 2.5 volt range.
      CODE_2V5:
      begin
        fullScaleMv_d = extend ? FS_3V_MV : FS_2V5_MV; // R10 R4
      end
      // Code 10 selects the five volt range.
      CODE_5V:
      begin
        fullScaleMv_d = extend ? FS_6V_MV : FS_5V_MV; // R10 R7
      end
    endcase
  end

  // Register the decoded magnitude; reset shows the default ten volts.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      fullScaleMv_q <= FS_10V_MV;
    end
    else
    begin
      fullScaleMv_q <= fullScaleMv_d;
    end
  end

endmodule
`default_nettype wire

// file: rtl/overrange_ctrl_regs.sv
// Extended-range enable registers with APB and host word access.
//
// How it works
// R1: Bit 15 picks read or write.
// R2: Bits 14..9 carry the register select.
// R3: Bit 8 reserved, always reads zero.
// R4: Bank A bit n extends channel n.
// R5: Bank A channels 0-3 use 0x04, 4-7 0x05.
// R6: Bank B channels 0-3 use 0x06, 4-7 0x07.
// R7: Clear bit keeps nominal range; resets to zero.
// R8: Bank B at 0xB, resets to 0x1600.
// R9: Bank A at 0xA, resets to 0x1400.
// R10: Codes decode to 10, 2.5, 5, 10 V.
// R11: Each channel outputs code plus extension bit.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module overrange_ctrl_regs
  import overrange_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host register word port, one word per valid cycle.
  input wire logic hostWordValid,
  input wire logic [15:0] hostWord,
  output logic [15:0] hostReadData,
  output logic hostReadValid,
  // Range code fields of the four range registers, two bits per channel.
  input wire logic [7:0] rangeWordA1,
  input wire logic [7:0] rangeWordA2,
  input wire logic [7:0] rangeWordB1,
  input wire logic [7:0] rangeWordB2,
  // Per channel {extend, code}; bank A channels 0-7, then bank B.
  output logic [47:0] rangeSel,
  // Per channel full-scale magnitude in millivolts, same order.
  output logic [223:0] fullScaleMv
);

  // Extension bits of bank A and bank B.
  logic [7:0] extA_q;
  logic [7:0] extB_q;
  // Registered read data and error for the APB access phase.
  logic [31:0] prdata_q;
  logic pslverr_q;
  // Registered host read answer.
  logic [15:0] hostReadData_q;
  logic hostReadValid_q;
  // Registered per-channel selection outputs.
  logic [47:0] rangeSel_q;
  // Decoded APB access strobes.
  logic apbSetup;
  logic apbWrite;
  logic apbHitA;
  logic apbHitB;
  // Decoded host word fields and strobes.
  logic hostDir;
  logic [5:0] hostSel;
  logic hostHitA;
  logic hostHitB;
  logic hostWrA;
  logic hostWrB;
  // Range code chosen for each channel.
  logic [1:0] chanCode [CH_TOTAL];
  // Extension bit for each channel.
  logic chanExt [CH_TOTAL];

  // Build the full register word from its select value and enable bits.
  function automatic logic [15:0] regWord(input logic [5:0] sel,
                                          input logic [7:0] ext);
    logic [15:0] w;
    w = 16'h0000;
    w[DIR_BIT] = DIR_READ;
    w[SEL_HI:SEL_LO] = sel; // R2
    w[RSVD_BIT] = 1'b0; // R3
    w[EXT_HI:0] = ext;
    return w;
  endfunction

  // Pick the two-bit code of one of four channels in a range word.
  function automatic logic [1:0] pickCode(input logic [7:0] word,
                                          input int slot);
    logic [1:0] c;
    c = word[slot * CODE_W +: CODE_W];
    return c;
  endfunction

  // APB decode: the setup cycle prepares the answer, access completes it.
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && pstrb[0];
  assign apbHitA = (paddr == ADDR_EXT_A); // R9
  assign apbHitB = (paddr == ADDR_EXT_B); // R8
  assign pready = psel && penable;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Host word decode: direction bit and register select field.
  assign hostDir = hostWord[DIR_BIT]; // R1
  assign hostSel = hostWord[SEL_HI:SEL_LO]; // R2
  assign hostHitA = hostWordValid && (hostSel == IDX_EXT_A);
  assign hostHitB = hostWordValid && (hostSel == IDX_EXT_B);
  assign hostWrA = hostHitA && (hostDir == DIR_WRITE); // R1
  assign hostWrB = hostHitB && (hostDir == DIR_WRITE); // R1
  assign hostReadData = hostReadData_q;
  assign hostReadValid = hostReadValid_q;

  // Bank A enables; an APB write wins over a host write in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      extA_q <= RST_EXT_BITS; // R7 R9
    end
    else if (apbWrite && apbHitA)
    begin
      extA_q <= pwdata[EXT_HI:0]; // R4
    end
    else if (hostWrA)
    begin
      extA_q <= hostWord[EXT_HI:0]; // R4
    end
  end

  // Bank B enables, written the same way as bank A.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      extB_q <= RST_EXT_BITS; // R7 R8
    end
    else if (apbWrite && apbHitB)
    begin
      extB_q <= pwdata[EXT_HI:0]; // R6
    end
    else if (hostWrB)
    begin
      extB_q <= hostWord[EXT_HI:0]; // R6
    end
  end

  // Capture APB read data and the error flag in the setup cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      prdata_q <= ZERO_WORD;
      pslverr_q <= 1'b0;
    end
    else if (apbSetup)
    begin
      // Upper sixteen bits of a mapped word read as zero.
      if (apbHitA)
      begin
        prdata_q <= {16'h0000, regWord(IDX_EXT_A, extA_q)}; // R3 R9
        pslverr_q <= 1'b0;
      end
      else if (apbHitB)
      begin
        prdata_q <= {16'h0000, regWord(IDX_EXT_B, extB_q)}; // R3 R8
        pslverr_q <= 1'b0;
      end
      else
      begin
        // Unmapped addresses answer zero with an error.
        prdata_q <= ZERO_WORD;
        pslverr_q <= 1'b1;
      end
    end
  end

  // Answer host read words one cycle later; others are ignored.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      hostReadData_q <= 16'h0000;
      hostReadValid_q <= 1'b0;
    end
    else
    begin
      hostReadValid_q <= 1'b0;
      // A read of bank A returns its full word.
      if (hostHitA && (hostDir == DIR_READ))
      begin
        hostReadData_q <= regWord(IDX_EXT_A, extA_q); // R1 R3
        hostReadValid_q <= 1'b1;
      end
      // A read of bank B returns its full word.
      else if (hostHitB && (hostDir == DIR_READ))
      begin
        hostReadData_q <= regWord(IDX_EXT_B, extB_q); // R1 R3
        hostReadValid_q <= 1'b1;
      end
    end
  end

  // Route each channel to its range code and extension bit.
  always_comb
  begin
    for (int i = 0; i < CH_PER_CODE_REG; i++)
    begin
      chanCode[i] = pickCode(rangeWordA1, i); // R5
      chanCode[i + CH_PER_CODE_REG] = pickCode(rangeWordA2, i); // R5
      chanCode[i + CH_PER_BANK] = pickCode(rangeWordB1, i); // R6
      chanCode[i + CH_PER_BANK + CH_PER_CODE_REG] =
        pickCode(rangeWordB2, i); // R6
    end
    for (int i = 0; i < CH_PER_BANK; i++)
    begin
      chanExt[i] = extA_q[i]; // R4
      chanExt[i + CH_PER_BANK] = extB_q[i]; // R6
    end
  end

  // Register the combined selection for the analog front end.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rangeSel_q <= '0;
    end
    else
    begin
      for (int i = 0; i < CH_TOTAL; i++)
      begin
        rangeSel_q[i * SEL_W +: SEL_W] <= {chanExt[i], chanCode[i]}; // R11
      end
    end
  end

  assign rangeSel = rangeSel_q;

  // One decoder per channel turns the selection into a magnitude.
  for (genvar g = 0; g < CH_TOTAL; g++)
  begin : gDec
    channel_range_map uMap (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .rangeCode(chanCode[g]),
      .extend(chanExt[g]),
      .fullScaleMv_q(fullScaleMv[g * FS_W +: FS_W])
    );
  end

endmodule
`default_nettype wire

// file: rtl/overrange_pkg.sv
// Constants shared by the overrange control register bank.
package overrange_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [5:0] IDX_EXT_A = 6'h0a;
  localparam logic [5:0] IDX_EXT_B = 6'h0b;
  localparam logic [7:0] ADDR_EXT_A = {IDX_EXT_A, 2'b00};
  localparam logic [7:0] ADDR_EXT_B = {IDX_EXT_B, 2'b00};

  // Bit positions within a 16-bit register word.
  localparam int DIR_BIT = 15;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 9;
  localparam int RSVD_BIT = 8;
  localparam int EXT_HI = 7;

  // Direction codes carried in the top bit of a register word.
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;

  // Reset values of the two extension registers.
  localparam logic [15:0] RST_EXT_A = 16'h1400;
  localparam logic [15:0] RST_EXT_B = 16'h1600;
  localparam logic [7:0] RST_EXT_BITS = 8'h00;

  // Channel counts and field widths.
  localparam int CH_PER_BANK = 8;
  localparam int CH_TOTAL = 16;
  localparam int CODE_W = 2;
  localparam int SEL_W = 3;
  localparam int FS_W = 14;
  localparam int CH_PER_CODE_REG = 4;

  // Two-bit range codes.
  localparam logic [1:0] CODE_10V_A = 2'b00;
  localparam logic [1:0] CODE_2V5 = 2'b01;
  localparam logic [1:0] CODE_5V = 2'b10;
  localparam logic [1:0] CODE_10V_B = 2'b11;

  // Full-scale magnitudes in millivolts, nominal and with 20% overrange.
  localparam logic [13:0] FS_10V_MV = 14'h2710;
  localparam logic [13:0] FS_5V_MV = 14'h1388;
  localparam logic [13:0] FS_2V5_MV = 14'h09c4;
  localparam logic [13:0] FS_12V_MV = 14'h2ee0;
  localparam logic [13:0] FS_6V_MV = 14'h1770;
  localparam logic [13:0] FS_3V_MV = 14'h0bb8;

  // Zero word returned for unmapped reads.
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// file: tb/host_word_model.sv
// Host controller model issuing register words.
`timescale 1ns/100ps
`default_nettype none
module host_word_model (
  input wire logic clk_sys,
  input wire logic [15:0] hostReadData,
  input wire logic hostReadValid,
  output logic hostWordValid,
  output logic [15:0] hostWord
);
  // Sends a word after g idle cycles; the answer is unknown if none came.
  task automatic xfer(input logic [15:0] w, input int g,
    output logic [15:0] r);
    repeat (g) @(posedge clk_sys);
    hostWordValid <= 1'b1;
    hostWord <= w;
    @(posedge clk_sys);
    hostWordValid <= 1'b0;
    hostWord <= ~w;
    @(posedge clk_sys);
    r = hostReadValid ? hostReadData : 16'hxxxx;
  endtask
  initial
  begin
    hostWordValid = 1'b0;
    hostWord = 16'h0000;
  end
endmodule
`default_nettype wire

// file: tb/overrange_ctrl_regs_monitor.sv
// Port checker for the overrange register bank.
`timescale 1ns/100ps
`default_nettype none
module overrange_ctrl_regs_monitor
  import overrange_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic hostWordValid,
  input wire logic [15:0] hostWord,
  input wire logic [15:0] hostReadData,
  input wire logic hostReadValid,
  input wire logic [7:0] rangeWordA1,
  input wire logic [47:0] rangeSel,
  input wire logic [223:0] fullScaleMv
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Access phase, mapped address, bank A extension bits.
  logic acc, hit;
  logic [7:0] extA;
  assign acc = psel && penable;
  assign hit = paddr == ADDR_EXT_A || paddr == ADDR_EXT_B;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      extA[i] = rangeSel[3*i+2];
    end
  end
  // Full scale in millivolts for {extend, code}.
  function automatic logic [13:0] fs(input logic [2:0] s);
    case (s[1:0])
      2'b01: return s[2] ? 14'h0bb8 : 14'h09c4;
      2'b10: return s[2] ? 14'h1770 : 14'h1388;
      default: return s[2] ? 14'h2ee0 : 14'h2710;
    endcase
  endfunction
  property p_err;
    acc |-> pslverr == !hit && (hit || prdata == '0);
  endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_sel;
    acc && hit |-> prdata[14:9] == paddr[7:2];
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_rsv;
    acc |-> !prdata[8] && !prdata[15];
  endproperty
  a_rsv: assert property (p_rsv) else $error("bad fixed bits");
  property p_hrd;
    hostWordValid && !hostWord[15] && hostWord[14:10] == 5'h05 |=>
      hostReadValid && hostReadData[14:9] == $past(hostWord[14:9]);
  endproperty
  a_hrd: assert property (p_hrd) else $error("no host answer");
  property p_hwr;
    hostWordValid && hostWord[15] |=> !hostReadValid;
  endproperty
  a_hwr: assert property (p_hwr) else $error("write answered");
  property p_ext;
    acc && pwrite && pstrb[0] && paddr == ADDR_EXT_A |->
      ##2 extA == $past(pwdata[7:0], 2);
  endproperty
  a_ext: assert property (p_ext) else $error("bad extend");
  property p_code;
    $past(nrst) && $past(nrst, 2) |->
      rangeSel[10:9] == $past(rangeWordA1[7:6]);
  endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_fs;
    fullScaleMv[195:182] == fs(rangeSel[41:39]);
  endproperty
  a_fs: assert property (p_fs) else $error("bad full scale");
endmodule
bind overrange_ctrl_regs overrange_ctrl_regs_monitor mon (.clk_sys, .nrst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr,
  .hostWordValid, .hostWord, .hostReadData, .hostReadValid, .rangeWordA1,
  .rangeSel, .fullScaleMv);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the overrange register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import overrange_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, pslverr, pready;
  logic hostWordValid, hostReadValid;
  // Error flag seen with the last APB answer.
  logic rdErr;
  logic [3:0] pstrb;
  logic [7:0] paddr, eA, eB;
  logic [31:0] pwdata, prdata, rd, codes;
  logic [15:0] hostWord, hostReadData, hr;
  logic [47:0] rangeSel;
  logic [223:0] fullScaleMv;
  int fail_count, checked, cycles;
  overrange_ctrl_regs dut (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .hostWordValid,
    .hostWord, .hostReadData, .hostReadValid, .rangeWordA1(codes[7:0]),
    .rangeWordA2(codes[15:8]), .rangeWordB1(codes[23:16]),
    .rangeWordB2(codes[31:24]), .rangeSel, .fullScaleMv);
  host_word_model host (.clk_sys, .hostReadData, .hostReadValid,
    .hostWordValid, .hostWord);
  // Clock of 20 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; read data lands in rd.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Expected read word of an extension register.
  function automatic logic [31:0] rw(input logic [5:0] i, input logic [7:0] e);
    return {17'h00000, i, 1'b0, e};
  endfunction
  function automatic logic [31:0] fsx(input logic [2:0] s);
    case (s[1:0])
      2'b01: return s[2] ? 32'h0bb8 : 32'h09c4;
      2'b10: return s[2] ? 32'h1770 : 32'h1388;
      default: return s[2] ? 32'h2ee0 : 32'h2710;
    endcase
  endfunction
  // Compares every channel's selection and full scale.
  task automatic chkCh;
    logic e;
    logic [1:0] c;
    for (int i = 0; i < 16; i++)
    begin
      e = i < 8 ? eA[i] : eB[i-8];
      c = codes[2*i +: 2];
      chk(32'(rangeSel[3*i +: 3]), 32'({e, c}));
      chk(32'(fullScaleMv[14*i +: 14]), fsx({e, c}));
    end
  endtask
  // Hang guard.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count++;
      end_of_test;
    end
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, codes, eA, eB} = '0;
    pstrb = 4'hf;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(32'h597ac408));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, ADDR_EXT_A, 32'h0);
    chk(rd, 32'h1400);
    chk(32'(rdErr), 32'h0);
    apb(1'b0, ADDR_EXT_B, 32'h0);
    chk(rd, 32'h1600);
    chkCh();
    $display("test reset done");
    for (int k = 0; k < 12; k++)
    begin
      eA = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
      eB = k < 2 ? ~eA : 8'($urandom);
      codes <= $urandom;
      apb(1'b1, ADDR_EXT_A, {24'($urandom), eA});
      host.xfer({DIR_WRITE, IDX_EXT_B, 1'b1, eB}, k % 3, hr);
      apb(1'b0, ADDR_EXT_A, $urandom);
      chk(rd, rw(IDX_EXT_A, eA));
      host.xfer({DIR_READ, IDX_EXT_B, 9'h000}, 0, hr);
      chk({16'h0000, hr}, rw(IDX_EXT_B, eB));
      chkCh();
    end
    $display("test random done");
    // A reset in mid-run brings both registers back to their reset words.
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    eA = 8'h00;
    eB = 8'h00;
    apb(1'b0, ADDR_EXT_A, 32'h0);
    chk(rd, {16'h0000, RST_EXT_A});
    apb(1'b0, ADDR_EXT_B, 32'h0);
    chk(rd, {16'h0000, RST_EXT_B});
    chkCh();
    $display("test mid reset done");
    apb(1'b1, 8'h30, 32'h000000ff);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    chk(32'(rdErr), 32'h1);
    // A write without its low byte strobe must leave bank A alone.
    pstrb <= 4'he;
    apb(1'b1, ADDR_EXT_A, 32'h000000a5);
    pstrb <= 4'hf;
    host.xfer({DIR_WRITE, 6'h0c, 9'h0ff}, 1, hr);
    host.xfer({DIR_READ, IDX_EXT_A, 9'h000}, 0, hr);
    chk({16'h0000, hr}, rw(IDX_EXT_A, eA));
    $display("test unmapped done");
    end_of_test;
  end
endmodule
`default_nettype wire
